/* verilog/afs_pkg.sv */
// Constants, register map and types shared by the availability fault supervisor
package afs_pkg;

  // Timebase
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned TICK_MS        = 10;
  localparam int unsigned TEST_MIN       = 5;
  localparam int unsigned TICK_CYC_DEF   = TICK_MS * CLK_MHZ * 1000;
  localparam int unsigned TEST_TICKS_DEF = TEST_MIN * 60 * 1000 / TICK_MS;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_COND     = 8'h10;

  // Sampled condition vector
  localparam int C_VOLT   = 0;
  localparam int C_RATE   = 1;
  localparam int C_PFAIL  = 2;
  localparam int C_ABN    = 3;
  localparam int C_POS    = 4;
  localparam int C_LOCK   = 5;
  localparam int C_IDLE   = 6;
  localparam int C_CUSTOM = 7;
  localparam int C_EXT    = 8;
  localparam int C_AUTO   = 9;
  localparam int C_FORCE  = 10;
  localparam int NCOND    = 11;
  localparam logic [NCOND-1:0] COND_RST = 11'h000;

  // Status register bits
  localparam int S_UNAVAIL = 0;
  localparam int S_INHIBIT = 1;
  localparam int S_LATCH   = 2;
  localparam int S_MOTOR   = 3;
  localparam int S_CUST    = 4;
  localparam int S_BUSY    = 5;
  localparam int S_OFF     = 6;
  localparam int NSTAT     = 7;

  // Interrupt events
  localparam int EV_UNAVAIL = 0;
  localparam int EV_TFAIL   = 1;
  localparam int EV_RESET   = 2;
  localparam int NEV        = 3;
  localparam logic [NEV-1:0] IRQ_MASK_RST = 3'h0;

  localparam int CTRL_TEST = 0;

  typedef enum logic [1:0] {TS_IDLE, TS_FIRST, TS_REPEAT} afs_test_e;

endpackage

/* verilog/afs_test_if.sv */
// Handshake between supervisor and self-test engine
`timescale 1ns/1ps
interface afs_test_if;
  logic start;
  logic busy;
  logic done;
  logic motor_fail;
  logic cust_fail;
  modport ctrl (output start, input busy, input done, input motor_fail, input cust_fail);
  modport test (input start, output busy, output done, output motor_fail, output cust_fail);
endinterface

/* verilog/afs_timebase.sv */
// Free-running timebase giving the sampling tick and the self-test tick
`timescale 1ns/1ps
module afs_timebase import afs_pkg::*; #(
  parameter int unsigned TICK_CYC   = TICK_CYC_DEF,
  parameter int unsigned TEST_TICKS = TEST_TICKS_DEF
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      tick_o,
  output logic      test_tick_o
);
  logic [31:0] cyc_q;
  logic [31:0] tks_q;
  wire         cyc_end = (cyc_q == TICK_CYC - 1);
  wire         tks_end = (tks_q == TEST_TICKS - 1);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_q       <= 32'h0;
      tks_q       <= 32'h0;
      tick_o      <= 1'b0;
      test_tick_o <= 1'b0;
    end else begin
      cyc_q       <= cyc_end ? 32'h0 : cyc_q + 32'h1;
      if (cyc_end) begin
        tks_q <= tks_end ? 32'h0 : tks_q + 32'h1;
      end
      tick_o      <= cyc_end;
      test_tick_o <= cyc_end && tks_end;
    end
  end
endmodule

/* verilog/afs_selftest.sv */
// Motorisation self-test engine with one confirming repeat
`timescale 1ns/1ps
module afs_selftest import afs_pkg::*; (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic motor_sense_ok_i,
  input  wire logic cust_input_ok_i,
  afs_test_if.test  tst
);
  afs_test_e state_q;
  logic      m1_q;
  logic      c1_q;
  logic      mf_q;
  logic      cf_q;
  logic      done_q;
  wire       fail_now = !motor_sense_ok_i || !cust_input_ok_i;

  assign tst.busy       = (state_q != TS_IDLE);
  assign tst.done       = done_q;
  assign tst.motor_fail = mf_q;
  assign tst.cust_fail  = cf_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= TS_IDLE;
      m1_q    <= 1'b0;
      c1_q    <= 1'b0;
      mf_q    <= 1'b0;
      cf_q    <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        TS_IDLE: begin
          if (tst.start) begin
            state_q <= TS_FIRST;
            mf_q    <= 1'b0;
            cf_q    <= 1'b0;
          end
        end
        // [R03] Repeat once on failure
        TS_FIRST: begin
          m1_q    <= !motor_sense_ok_i;
          c1_q    <= !cust_input_ok_i;
          state_q <= fail_now ? TS_REPEAT : TS_IDLE;
          done_q  <= !fail_now;
        end
        // [R03] Confirm only double failures
        TS_REPEAT: begin
          mf_q    <= m1_q && !motor_sense_ok_i;
          cf_q    <= c1_q && !cust_input_ok_i;
          state_q <= TS_IDLE;
          done_q  <= 1'b1;
        end
        default: state_q <= TS_IDLE;
      endcase
    end
  end

  // [R03] repeat follows failure
  repeat_after_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R03]
    (state_q == TS_FIRST && fail_now) |=> state_q == TS_REPEAT)
    else $error("failed first test not repeated");
  // [R03] confirmed only by two fails
  confirm_two_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R03]
    $rose(mf_q) |-> !$past(motor_sense_ok_i, 1) && !$past(motor_sense_ok_i, 2))
    else $error("motor failure confirmed without two failing tests");
  cov_repeat_pass_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == TS_REPEAT && !fail_now);
endmodule

/* verilog/afs_supervisor.sv */
// Availability and fault supervisor for the motorisation module
//
// How it works
// [R01] Relay closed only while module available
// [R02] Self-test at power-up, manual-to-auto, every 5 min
// [R03] Failed test repeated once, confirmed if twice
// [R04] Unavailable: relay open, ready off, fault on
// [R05] Fault indication latched until reset
// [R06] Latch cleared by auto-manual-auto selector cycle
// [R07] Availability informative; inhibit only listed causes
// [R08] Manual, supply, rate, powerfail: unavailable, inhibit
// [R09] Abnormal, position, locked, idle current inhibit
// [R10] Motor, customer test, customisation, external: no inhibit
// [R11] Conditions sampled every 10 ms, motor 5 min
// [R12] Fault/manual indicator in manual or fault
// [R13] Fault/manual indicator lit during force-off
// [R14] Force-off drives off, overrides, reports unavailable
// [R15] All clear and reset restores availability
// [R16] One free-running timebase gives both ticks
`timescale 1ns/1ps
module afs_supervisor import afs_pkg::*; #(
  parameter int unsigned TICK_CYC   = TICK_CYC_DEF,
  parameter int unsigned TEST_TICKS = TEST_TICKS_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        automatic_position_i,
  input  wire logic        force_off_i,
  input  wire logic        supply_out_of_range_i,
  input  wire logic        op_rate_fault_i,
  input  wire logic        power_fail_i,
  input  wire logic        abnormal_switch_i,
  input  wire logic        position_missed_i,
  input  wire logic        locked_mode_i,
  input  wire logic        idle_current_i,
  input  wire logic        bad_customisation_i,
  input  wire logic        ext_fault_i,
  input  wire logic        motor_sense_ok_i,
  input  wire logic        cust_input_ok_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  output logic             availability_relay_contact_o,
  output logic             ready_led_o,
  output logic             fault_led_o,
  output logic             motor_inhibit_o,
  output logic             drive_off_o,
  output logic             irq_o
);

  afs_test_if tst ();

  logic              tick;
  logic              test_tick;
  logic [NCOND-1:0]  s_q;
  logic [NCOND-1:0]  s_d;
  logic              latch_q;
  logic              latch_d;
  logic              por_q;
  logic              unavail_q;
  logic [NEV-1:0]    irq_stat_q;
  logic [NEV-1:0]    irq_stat_d;
  logic [NEV-1:0]    irq_mask_q;

  // [R16] Shared timebase
  afs_timebase #(
    .TICK_CYC   (TICK_CYC),
    .TEST_TICKS (TEST_TICKS)
  ) u_timebase (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .tick_o      (tick),
    .test_tick_o (test_tick)
  );

  afs_selftest u_selftest (
    .clk_i            (clk_i),
    .rstn_i           (rstn_i),
    .motor_sense_ok_i (motor_sense_ok_i),
    .cust_input_ok_i  (cust_input_ok_i),
    .tst              (tst)
  );

  // Pin picture as one vector
  wire [NCOND-1:0] pins = {force_off_i, automatic_position_i, ext_fault_i,
                           bad_customisation_i, idle_current_i, locked_mode_i,
                           position_missed_i, abnormal_switch_i, power_fail_i,
                           op_rate_fault_i, supply_out_of_range_i};

  // [R11] Conditions move only on the sampling tick
  assign s_d = tick ? pins : s_q;

  wire auto_d   = s_d[C_AUTO];
  wire force_d  = s_d[C_FORCE];
  wire manual_d = !auto_d;

  // [R06] Selector back in auto after manual
  wire reset_ev = tick && pins[C_AUTO] && !s_q[C_AUTO];

  // [R11] Motor detection only from self-tests: 5 min, power-up, return to auto, register request
  wire test_fail = (tst.motor_fail || tst.cust_fail) && !reset_ev;

  // [R08] Inhibiting causes at any mode
  wire inhib_any = s_d[C_VOLT] || s_d[C_RATE] || s_d[C_PFAIL];
  // [R09] Inhibiting causes outside manual
  wire inhib_auto = auto_d && (s_d[C_ABN] || s_d[C_POS] || s_d[C_LOCK] || s_d[C_IDLE]);
  // [R10] Non-inhibiting causes
  wire info_only = s_d[C_CUSTOM] || s_d[C_EXT] || test_fail;

  wire fault_now = auto_d && (inhib_any || inhib_auto || info_only);

  // [R05] Latch holds; a new fault beats the reset
  assign latch_d = (latch_q && !reset_ev) || fault_now;

  // [R07] Inhibit only for designated causes
  wire inhibit_d = manual_d || force_d || inhib_any || inhib_auto;

  // [R14] Force-off reports unavailable
  wire unavail_d = manual_d || force_d || inhib_any || inhib_auto || info_only || latch_d;

  // [R02] Test triggers; busy engine ignores extra starts
  wire sw_test  = reg_wr_i && (reg_addr_i == ADDR_CTRL) && reg_wdata_i[CTRL_TEST];
  wire test_req = por_q || reset_ev || test_tick || sw_test;
  assign tst.start = test_req && !tst.busy;

  // Register decode
  wire wr_stat = reg_wr_i && (reg_addr_i == ADDR_IRQ_STAT);
  wire wr_mask = reg_wr_i && (reg_addr_i == ADDR_IRQ_MASK);

  wire [NEV-1:0] events;
  assign events[EV_UNAVAIL] = unavail_d && !unavail_q;
  assign events[EV_TFAIL]   = tst.done && (tst.motor_fail || tst.cust_fail);
  assign events[EV_RESET]   = reset_ev && latch_q;

  // Event wins over a simultaneous write-one-to-clear
  wire [NEV-1:0] w1c = wr_stat ? reg_wdata_i[NEV-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~w1c) | events;

  wire [NSTAT-1:0] status;
  assign status[S_UNAVAIL] = unavail_q;
  assign status[S_INHIBIT] = motor_inhibit_o;
  assign status[S_LATCH]   = latch_q;
  assign status[S_MOTOR]   = tst.motor_fail;
  assign status[S_CUST]    = tst.cust_fail;
  assign status[S_BUSY]    = tst.busy;
  assign status[S_OFF]     = drive_off_o;

  wire hit_ctrl = (reg_addr_i == ADDR_CTRL);
  wire hit_stat = (reg_addr_i == ADDR_STATUS);
  wire hit_irqs = (reg_addr_i == ADDR_IRQ_STAT);
  wire hit_mask = (reg_addr_i == ADDR_IRQ_MASK);
  wire hit_cond = (reg_addr_i == ADDR_COND);

  // Control bit is a pulse, so it reads back as zero
  wire [31:0] rd_mux = hit_ctrl ? 32'h0 :
                       hit_stat ? {{(32-NSTAT){1'b0}}, status} :
                       hit_irqs ? {{(32-NEV){1'b0}}, irq_stat_q} :
                       hit_mask ? {{(32-NEV){1'b0}}, irq_mask_q} :
                       hit_cond ? {{(32-NCOND){1'b0}}, s_q} : 32'h0;

  // Manual until first sample, so nothing shows available before it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q     <= COND_RST;
      latch_q <= 1'b0;
      por_q   <= 1'b1;
    end else begin
      s_q     <= s_d;
      latch_q <= latch_d;
      por_q   <= 1'b0;
    end
  end

  // [R04] Relay, ready and fault outputs follow the availability verdict together
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unavail_q                    <= 1'b1;
      availability_relay_contact_o <= 1'b0;
      ready_led_o                  <= 1'b0;
      fault_led_o                  <= 1'b1;
      motor_inhibit_o              <= 1'b1;
      drive_off_o                  <= 1'b0;
    end else begin
      unavail_q                    <= unavail_d;
      // [R01] Relay closed while available
      availability_relay_contact_o <= !unavail_d;
      // [R15] Ready back once everything clear
      ready_led_o                  <= !unavail_d;
      // [R12] Manual or fault lights the indicator
      // [R13] Force-off lights it too
      fault_led_o                  <= unavail_d;
      motor_inhibit_o              <= inhibit_d;
      // [R14] Off order overrides all others
      drive_off_o                  <= force_d;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_q  <= '0;
      irq_mask_q  <= IRQ_MASK_RST;
      irq_o       <= 1'b0;
      reg_rdata_o <= 32'h0;
    end else begin
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= wr_mask ? reg_wdata_i[NEV-1:0] : irq_mask_q;
      irq_o       <= |(irq_stat_d & (wr_mask ? reg_wdata_i[NEV-1:0] : irq_mask_q));
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic [2:0] tick_age_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_age_q <= 3'h7;
    end else begin
      tick_age_q <= tick ? 3'h0 : (tick_age_q == 3'h7 ? tick_age_q : tick_age_q + 3'h1);
    end
  end

  // [R11] sample changes only after a tick
  sample_on_tick_a: assert property ( // [R11]
    $changed(s_q) |-> tick_age_q == 3'h0)
    else $error("condition sample changed away from the sampling tick");

  // [R01] relay follows availability
  relay_avail_a: assert property ( // [R01]
    availability_relay_contact_o |-> s_q[C_AUTO] && !s_q[C_FORCE] && !latch_q)
    else $error("relay closed while unavailable");

  // [R04] unavailable output set
  unavail_outs_a: assert property ( // [R04]
    !availability_relay_contact_o |-> fault_led_o && !ready_led_o)
    else $error("unavailable without fault on and ready off");

  // [R08] manual mode inhibits
  manual_inhibit_a: assert property ( // [R08]
    !s_q[C_AUTO] |-> motor_inhibit_o && !availability_relay_contact_o && fault_led_o)
    else $error("manual mode did not inhibit and drop availability");

  // [R09] inhibit on abnormal switching in auto
  auto_inhibit_a: assert property ( // [R09]
    (s_q[C_AUTO] && s_q[C_ABN] && !tick) |=> motor_inhibit_o)
    else $error("abnormal switching in auto did not inhibit");

  // [R10] informative causes do not inhibit
  info_noinhib_a: assert property ( // [R10]
    (!tick && s_q[C_AUTO] && !s_q[C_FORCE] && s_q[C_EXT] && s_q[C_VOLT:C_VOLT] == 1'b0
     && !s_q[C_RATE] && !s_q[C_PFAIL] && !s_q[C_ABN] && !s_q[C_POS] && !s_q[C_LOCK]
     && !s_q[C_IDLE]) |=> !motor_inhibit_o && !availability_relay_contact_o)
    else $error("external fault handled wrongly");

  // [R05] latch holds without selector cycle
  latch_hold_a: assert property ( // [R05]
    (latch_q && !reset_ev) |=> latch_q)
    else $error("fault latch dropped without reset");

  // [R06] selector cycle clears latch
  latch_clear_a: assert property ( // [R06]
    (latch_q && reset_ev && !fault_now) |=> !latch_q)
    else $error("selector cycle did not clear fault latch");

  // [R02] selector return starts the test
  test_start_a: assert property ( // [R02]
    (reset_ev && !tst.busy) |=> tst.busy)
    else $error("self-test not started on return to auto");

  // [R14] force-off overrides
  force_off_a: assert property ( // [R14]
    (s_q[C_FORCE] && !tick) |=> drive_off_o && fault_led_o && !availability_relay_contact_o)
    else $error("force-off not driving off and unavailable");

  // [R15] all clear restores availability
  restore_a: assert property ( // [R15]
    (!tick && !unavail_d && !latch_q) |=> availability_relay_contact_o && ready_led_o
                                         && !fault_led_o)
    else $error("availability not restored when clear");

  // Interrupt tracks the masked sticky bits
  irq_level_a: assert property (
    irq_o == |(irq_stat_q & irq_mask_q))
    else $error("interrupt output mismatch");

  // Set beats a same-cycle write-one-to-clear
  event_sticky_a: assert property (
    (events != '0) |=> ((irq_stat_q & $past(events)) == $past(events)))
    else $error("interrupt event lost");

  // Read data only in the cycle after a read
  rdata_pulse_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");

  // [R04] ready and fault opposite
  ready_tracks_a: assert property ( // [R04]
    ready_led_o == availability_relay_contact_o
    && fault_led_o != availability_relay_contact_o)
    else $error("ready and fault indicators disagree");

  // [R05] latched fault keeps indicator
  latch_led_a: assert property ( // [R05]
    latch_q |-> fault_led_o && !availability_relay_contact_o)
    else $error("latched fault without fault indicator");

  // [R08] supply, rate, powerfail inhibit
  supply_inhibit_a: assert property ( // [R08]
    (s_q[C_VOLT] || s_q[C_RATE] || s_q[C_PFAIL]) |-> motor_inhibit_o
    && !availability_relay_contact_o)
    else $error("inhibiting cause did not inhibit");

  // [R07] inhibit only from listed causes
  inhibit_cause_a: assert property ( // [R07]
    motor_inhibit_o |-> !s_q[C_AUTO] || s_q[C_FORCE] || s_q[C_VOLT] || s_q[C_RATE]
    || s_q[C_PFAIL] || s_q[C_ABN] || s_q[C_POS] || s_q[C_LOCK] || s_q[C_IDLE])
    else $error("motor inhibited without an inhibiting cause");

  // [R13] force-off lights indicator
  force_led_a: assert property ( // [R13]
    s_q[C_FORCE] |-> fault_led_o && !ready_led_o)
    else $error("force-off without fault indicator");

  // [R14] off order follows force input
  off_follows_a: assert property ( // [R14]
    drive_off_o == s_q[C_FORCE])
    else $error("off order differs from sampled force input");

  // [R02] power-up starts a test
  power_up_test_a: assert property ( // [R02]
    $fell(por_q) |-> tst.busy)
    else $error("no self-test at power-up");

  // [R02] periodic tick starts a test
  periodic_test_a: assert property ( // [R02]
    (test_tick && !tst.busy) |=> tst.busy)
    else $error("periodic self-test not started");

  // [R16] ticks spaced; holds while a tick period is at least eight cycles
  tick_spacing_a: assert property ( // [R16]
    tick |-> tick_age_q == 3'h7)
    else $error("sampling ticks too close together");

  // [R16] test tick on a sampling tick
  test_on_tick_a: assert property ( // [R16]
    test_tick |-> tick)
    else $error("self-test tick off the sampling tick");

  cov_fault_reset_c: cover property (latch_q && reset_ev ##1 !latch_q);
  cov_test_fail_c:   cover property (tst.done && tst.motor_fail);
  cov_force_off_c:   cover property ($rose(drive_off_o));
  cov_restore_c:     cover property ($rose(availability_relay_contact_o));

endmodule

/* testbench/afs_mech_model.sv */
// Model of the motor mechanism and customer input wiring read by the self-test
`timescale 1ns/1ps
module afs_mech_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] mode_i,
  output logic            motor_sense_ok_o,
  output logic            cust_input_ok_o
);
  logic flip_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flip_q <= 1'b0;
    end else begin
      flip_q <= ~flip_q;
    end
  end

  // Mode 1 motor absent, 2 loose lead flipping every cycle, 3 customer input broken
  assign motor_sense_ok_o = (mode_i == 2'h0) || (mode_i == 2'h3) || ((mode_i == 2'h2) && flip_q);
  assign cust_input_ok_o  = (mode_i != 2'h3);
endmodule

/* testbench/tb_afs_supervisor.sv */
// Self-checking testbench for the availability fault supervisor
`timescale 1ns/1ps
module tb_afs_supervisor import afs_pkg::*; ;
  localparam int unsigned TK = 20;
  localparam int unsigned TT = 5;
  logic             clk_i;
  logic             rstn_i;
  logic [NCOND-1:0] cond;
  logic [7:0]       reg_addr_i;
  logic [31:0]      reg_wdata_i;
  logic             reg_wr_i;
  logic             reg_rd_i;
  logic [31:0]      reg_rdata_o;
  logic             relay, ready, fault, inhibit, drive_off, irq;
  logic [1:0]       mode;
  logic             motor_ok, cust_ok;
  logic [31:0]      rd_v;
  int               n_errors, samples_checked, cycles;
  int               inh[7] = '{C_VOLT, C_RATE, C_PFAIL, C_ABN, C_POS, C_LOCK, C_IDLE};
  int               noinh[2] = '{C_CUSTOM, C_EXT};

  afs_supervisor #(.TICK_CYC(TK), .TEST_TICKS(TT)) u_afs_supervisor (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .automatic_position_i(cond[C_AUTO]), .force_off_i(cond[C_FORCE]),
    .supply_out_of_range_i(cond[C_VOLT]), .op_rate_fault_i(cond[C_RATE]),
    .power_fail_i(cond[C_PFAIL]), .abnormal_switch_i(cond[C_ABN]),
    .position_missed_i(cond[C_POS]), .locked_mode_i(cond[C_LOCK]),
    .idle_current_i(cond[C_IDLE]), .bad_customisation_i(cond[C_CUSTOM]),
    .ext_fault_i(cond[C_EXT]), .motor_sense_ok_i(motor_ok), .cust_input_ok_i(cust_ok),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .availability_relay_contact_o(relay), .ready_led_o(ready), .fault_led_o(fault),
    .motor_inhibit_o(inhibit), .drive_off_o(drive_off), .irq_o(irq));

  afs_mech_model u_afs_mech_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode),
    .motor_sense_ok_o(motor_ok), .cust_input_ok_o(cust_ok));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("wrong value at %0t: run did not complete", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Relay, ready, fault led, inhibit in that order
  task automatic outs(input logic [3:0] exp, input string msg);
    chk({28'h0, relay, ready, fault, inhibit}, {28'h0, exp}, msg);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask

  task automatic setc(input int idx, input logic v);
    @(posedge clk_i);
    cond[idx] <= v;
  endtask

  // Two full sample periods so a change is surely taken and shown
  task automatic settle();
    repeat (2 * TK + 5) @(posedge clk_i);
    #1;
  endtask

  // Operator fault reset: automatic to manual and back
  task automatic sel_cycle();
    setc(C_AUTO, 1'b0);
    settle();
    outs(4'b0011, "manual mode");
    setc(C_AUTO, 1'b1);
    settle();
    outs(4'b1100, "after selector cycle");
  endtask

  initial begin
    rstn_i      = 1'b0;
    cond        = COND_RST;
    mode        = 2'h0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    @(posedge clk_i);
    #1 outs(4'b0011, "in reset");
    chk({31'h0, drive_off}, 32'h0, "drive off in reset");
    @(posedge clk_i);
    rstn_i <= 1'b1;
    setc(C_AUTO, 1'b1);
    settle();
    outs(4'b1100, "first available");
    rd(ADDR_STATUS);
    chk(rd_v, 32'h0, "status clear");
    rd(ADDR_COND);
    chk(rd_v, 32'h1 << C_AUTO, "sampled vector");
    rd(ADDR_CTRL);
    chk(rd_v, 32'h0, "ctrl reads zero");
    rd(8'h14);
    chk(rd_v, 32'h0, "unmapped read");
    $display("test reset and idle done");

    foreach (inh[i]) begin
      setc(inh[i], 1'b1);
      settle();
      outs(4'b0011, "inhibiting cause");
      setc(inh[i], 1'b0);
      settle();
      chk({29'h0, relay, ready, fault}, 32'h1, "fault held");
      sel_cycle();
    end
    $display("test inhibiting causes done");

    foreach (noinh[i]) begin
      setc(noinh[i], 1'b1);
      settle();
      outs(4'b0010, "non-inhibiting cause");
      setc(noinh[i], 1'b0);
      settle();
      chk({29'h0, relay, ready, fault}, 32'h1, "fault held");
      sel_cycle();
    end
    $display("test non-inhibiting causes done");

    setc(C_FORCE, 1'b1);
    settle();
    chk({29'h0, relay, fault, drive_off}, 32'h3, "force off");
    setc(C_FORCE, 1'b0);
    settle();
    outs(4'b1100, "force released");
    chk({31'h0, drive_off}, 32'h0, "drive off released");
    $display("test force off done");

    // Periodic test must find the missing motor without any request
    mode <= 2'h1;
    repeat ((TT + 2) * TK) @(posedge clk_i);
    rd(ADDR_STATUS);
    chk({31'h0, rd_v[S_MOTOR]}, 32'h1, "motor missing");
    outs(4'b0010, "motor missing outputs");
    mode <= 2'h0;
    sel_cycle();
    $display("test periodic self-test done");

    rd(ADDR_IRQ_STAT);
    chk({31'h0, rd_v[EV_TFAIL]}, 32'h1, "test fail event");
    // Mask bits enable the interrupt and all reset to zero
    chk({31'h0, irq}, 32'h0, "irq held by reset mask");
    wr(ADDR_IRQ_MASK, 32'h7);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, irq}, 32'h1, "irq raised");
    rd(ADDR_IRQ_MASK);
    chk(rd_v, 32'h7, "mask readback");
    wr(ADDR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(ADDR_IRQ_STAT);
    chk(rd_v, 32'h0, "status cleared");
    wr(ADDR_IRQ_MASK, 32'h0);
    $display("test interrupts done");

    // A single bad reading is not enough to fail the test
    mode <= 2'h2;
    wr(ADDR_CTRL, 32'h1);
    repeat (10) @(posedge clk_i);
    rd(ADDR_STATUS);
    chk({31'h0, rd_v[S_MOTOR]}, 32'h0, "flaky motor not confirmed");
    outs(4'b1100, "still available");
    mode <= 2'h3;
    wr(ADDR_CTRL, 32'h1);
    repeat (10) @(posedge clk_i);
    rd(ADDR_STATUS);
    chk({31'h0, rd_v[S_CUST]}, 32'h1, "customer input fail");
    settle();
    outs(4'b0010, "customer fail outputs");
    mode <= 2'h0;
    sel_cycle();
    $display("test requested self-test done");
    tally_and_finish();
  end
endmodule
